// *** tb/muif_assertions.sv ***
// Concurrent checks on the dispatcher's top-level ports
`timescale 1ns/1ps
module muif_chk #(
  parameter int FLASH_CYC = 10,
  parameter int VIEW_CYC = 10
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Meter state and controls
  input wire logic code_granted,
  input wire logic full_prog_allowed,
  input wire logic input_freeze,
  input wire logic outputs_freeze,
  input wire logic adc_suspend,
  input wire logic adc_restart,
  input wire logic signed [31:0] display_value,
  input wire logic reset_indicator,
  input wire logic gross_view_indicator,
  input wire logic net_view_indicator
);
  int flash_cnt;
  int view_cnt;
  // Length of the running indicator pulses
  always_ff @(posedge ref_clk)
  begin
    flash_cnt <= (srst || !reset_indicator) ? 0 : flash_cnt + 1;
    view_cnt <= (srst || !(gross_view_indicator || net_view_indicator)) ? 0 : view_cnt + 1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait state");
  lock_grant_a: assert property (code_granted |-> full_prog_allowed)
    else $error("granted code still locked out");
  freeze_hold_a: assert property (input_freeze && $past(input_freeze) |-> $stable(display_value))
    else $error("display moved while frozen");
  sync_freeze_a: assert property (adc_suspend |-> input_freeze && outputs_freeze)
    else $error("suspend without freeze");
  restart_due_a: assert property ($fell(adc_suspend) |-> ##[1:2] adc_restart)
    else $error("no restart after suspend");
  restart_once_a: assert property (adc_restart |=> !adc_restart)
    else $error("restart longer than one cycle");
  flash_len_a: assert property ($fell(reset_indicator) |-> flash_cnt == FLASH_CYC)
    else $error("reset indicator length wrong");
  view_excl_a: assert property (!(gross_view_indicator && net_view_indicator))
    else $error("both view indicators lit");
  view_len_a: assert property ($fell(gross_view_indicator || net_view_indicator) |-> view_cnt == VIEW_CYC)
    else $error("view indicator length wrong");
endmodule // muif_chk

bind muif_top muif_chk #(.FLASH_CYC(FLASH_CYC), .VIEW_CYC(VIEW_CYC)) i_muif_chk (.ref_clk, .srst,
  .avs_read, .avs_write, .avs_waitrequest, .code_granted, .full_prog_allowed, .input_freeze,
  .outputs_freeze, .adc_suspend, .adc_restart, .display_value, .reset_indicator,
  .gross_view_indicator, .net_view_indicator);

// *** tb/muif_operator.sv ***
// Operator model: front-panel keys and external contacts with bounce
`timescale 1ns/1ps
module muif_operator (
  // Clock
  input wire logic ref_clk,
  // Levels the bench asks for
  input wire logic [8:0] want,
  // Raw contacts and keys
  output logic [2:0] external_control_input,
  output logic [4:0] function_key,
  output logic display_cycle_key
);
  logic [8:0] last = 9'h000;
  logic [8:0] chg = 9'h000;
  logic [8:0] raw = 9'h000;
  logic [2:0] bnc = 3'h0;
  // Contacts chatter for three cycles after each change
  always_ff @(posedge ref_clk)
  begin
    last <= want;
    chg <= (want != last) ? (want ^ last) : chg;
    bnc <= (want != last) ? 3'h3 : ((bnc != 3'h0) ? bnc - 3'h1 : bnc);
    raw <= bnc[0] ? (want ^ chg) : want;
  end
  // Split into the three groups of pins
  assign {display_cycle_key, function_key, external_control_input} = raw;
endmodule // muif_operator

// *** tb/muif_top_tb.sv ***
// Self-checking bench for the meter input dispatcher
`timescale 1ns/1ps
module muif_top_tb;
  import muif_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, display_cycle_key;
  logic [2:0] external_control_input;
  logic [4:0] function_key;
  logic [8:0] want = 9'h000;
  logic code_granted = 1'b0;
  logic program_mode = 1'b0;
  logic signed [17:0] gross_value = 18'sh0;
  logic sample_valid = 1'b0;
  logic signed [31:0] display_value;
  muif_view_t display_view;
  logic reset_indicator, gross_view_indicator, net_view_indicator, full_prog_allowed;
  logic input_freeze, outputs_freeze, adc_suspend, adc_restart;
  int num_errors = 0;
  int samples_checked = 0;
  // Short counts keep the run brief
  muif_top #(.DEB_CYC(4), .LONG_CYC(40), .FLASH_CYC(10), .VIEW_CYC(10)) i_muif_top (.ref_clk, .srst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
    .avs_waitrequest, .external_control_input, .function_key, .display_cycle_key, .program_mode,
    .code_granted, .gross_value, .sample_valid, .display_value, .display_view, .reset_indicator,
    .gross_view_indicator, .net_view_indicator, .full_prog_allowed, .input_freeze, .outputs_freeze,
    .adc_suspend, .adc_restart);
  muif_operator i_muif_operator (.ref_clk, .want, .external_control_input, .function_key,
    .display_cycle_key);
  // Clock
  initial forever #20 ref_clk = ~ref_clk;
  // Compare seen with expected
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // One Avalon transfer held until waitrequest drops
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    q = avs_readdata;
    if (n == 20)
      chk(32'h1, 32'h0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Operator source level, then settle past debounce
  task automatic src(input int i, input logic v);
    want[i] <= v;
    repeat (16) @(posedge ref_clk);
  endtask
  task automatic tap(input int i);
    src(i, 1'b1);
    src(i, 1'b0);
  endtask
  // One new conversion
  task automatic samp;
    sample_valid <= 1'b1;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  // Factory state, unmapped place, source without function
  task automatic t_reset;
    rd(5'h00, 32'h0);
    rd(5'h04, 32'h0);
    rd(5'h08, 32'h0);
    wr(5'h1c, 32'hffff_ffff);
    rd(5'h1c, 32'h0);
    src(0, 1'b1);
    bus(1'b0, 5'h10, 32'h0);
    chk({31'h0, q[16]}, 32'h1);
    chk(display_value, 32'h0);
    src(0, 1'b0);
  endtask
  // Tare from an input, then from a key sharing it
  task automatic t_tare;
    gross_value <= 18'sd100;
    samp;
    chk(display_value, 32'd100);
    wr(5'h00, 32'h2);
    tap(0);
    chk(display_value, 32'h0);
    rd(5'h0c, 32'hffff_ff9c);
    wr(5'h04, 32'h200);
    gross_value <= 18'sd150;
    samp;
    tap(5);
    samp;
    chk(display_value, 32'h0);
    rd(5'h0c, 32'hffff_ff6a);
  endtask
  // Absolute view held by input, toggled by key
  task automatic t_relabs;
    wr(5'h00, 32'h30);
    src(1, 1'b1);
    samp;
    chk(display_value, 32'd150);
    bus(1'b0, 5'h10, 32'h0);
    chk({31'h0, q[1]}, 32'h1);
    src(1, 1'b0);
    samp;
    chk(display_value, 32'h0);
    wr(5'h04, 32'h3);
    tap(3);
    samp;
    chk(display_value, 32'd150);
    tap(3);
    samp;
    chk(display_value, 32'h0);
    program_mode <= 1'b1;
    tap(3);
    samp;
    chk(display_value, 32'h0);
    src(1, 1'b1);
    chk(display_value, 32'd150);
    src(1, 1'b0);
    program_mode <= 1'b0;
  endtask
  // Lock-out and its override
  task automatic t_lock;
    wr(5'h00, 32'h100);
    src(2, 1'b1);
    chk({31'h0, full_prog_allowed}, 32'h0);
    code_granted <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({31'h0, full_prog_allowed}, 32'h1);
    code_granted <= 1'b0;
    src(2, 1'b0);
    chk({31'h0, full_prog_allowed}, 32'h1);
  endtask
  // Display hold, hold-all and synchronise
  task automatic t_hold;
    int n;
    n = 0;
    wr(5'h00, 32'h654);
    src(0, 1'b1);
    gross_value <= 18'sd300;
    samp;
    chk(display_value, 32'h0);
    src(0, 1'b0);
    samp;
    chk(display_value, 32'd150);
    src(1, 1'b1);
    chk({input_freeze, outputs_freeze}, 32'h3);
    gross_value <= 18'sd400;
    samp;
    chk(display_value, 32'd150);
    src(1, 1'b0);
    samp;
    chk(display_value, 32'd250);
    src(2, 1'b1);
    chk({31'h0, adc_suspend}, 32'h1);
    want[2] <= 1'b0;
    repeat (20)
    begin
      @(posedge ref_clk);
      n += (adc_restart === 1'b1);
    end
    chk(n, 32'h1);
  endtask
  // Secondary key function with empty primary
  task automatic t_key2nd;
    wr(5'h04, 32'h0);
    wr(5'h08, 32'h20);
    tap(4);
    samp;
    chk(display_value, 32'd250);
    src(4, 1'b1);
    repeat (50) @(posedge ref_clk);
    src(4, 1'b0);
    samp;
    chk(display_value, 32'h0);
  endtask
  // Totalizer reset, enable, batch and peak reset
  task automatic t_total;
    wr(5'h00, 32'h9b);
    gross_value <= 18'sd410;
    samp;
    tap(1);
    rd(5'h14, 32'h0);
    samp;
    rd(5'h14, 32'h0);
    src(0, 1'b1);
    samp;
    samp;
    rd(5'h14, 32'd20);
    src(0, 1'b0);
    samp;
    rd(5'h14, 32'd20);
    wr(5'h00, 32'h7);
    tap(0);
    rd(5'h14, 32'd30);
    samp;
    rd(5'h14, 32'd30);
    wr(5'h00, 32'hd);
    gross_value <= 18'sd405;
    samp;
    tap(0);
    rd(5'h18, 32'd5);
    wr(5'h00, 32'h8c);
    src(0, 1'b1);
    chk({30'h0, display_view}, 32'h2);
    chk(display_value, 32'd5);
    tap(8);
    chk({30'h0, display_view}, 32'h0);
    src(0, 1'b0);
    src(1, 1'b1);
    chk(display_value, 32'd35);
    src(1, 1'b0);
  endtask
  // Verdict and end of run
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_tare;
    t_relabs;
    t_lock;
    t_hold;
    t_key2nd;
    t_total;
    give_verdict;
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    give_verdict;
  end
endmodule // muif_top_tb

// *** verilog/muif_debounce.sv ***
// Synchroniser, debouncer and long-hold timer for every source
`timescale 1ns/1ps
module muif_debounce #(
  parameter int N = 9,
  parameter int DEB_CYC = 250000,
  parameter int LONG_CYC = 75000000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Raw sources, active high
  input wire logic [N-1:0] raw,
  // Cleaned results
  muif_src_if.drv src
);
  localparam int DW = $clog2(DEB_CYC + 1);
  localparam int LW = $clog2(LONG_CYC + 1);

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_ch
      logic s1, s2, lvl, rise, lrise, llvl;
      logic [DW-1:0] deb_cnt;
      logic [LW-1:0] long_cnt;
      // Two-flop synchroniser
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
        end
        else
        begin
          s1 <= raw[i];
          s2 <= s1;
        end
      end
      // Level accepted only after it stays stable
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          deb_cnt <= '0;
          lvl <= 1'b0;
          rise <= 1'b0;
        end
        else
        begin
          rise <= 1'b0;
          if (s2 == lvl)
            deb_cnt <= '0;
          else if (deb_cnt == DW'(DEB_CYC - 1))
          begin
            deb_cnt <= '0;
            lvl <= s2;
            rise <= s2;
          end
          else
            deb_cnt <= deb_cnt + 1'b1;
        end
      end
      // Hold timer for secondary key action
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          long_cnt <= '0;
          lrise <= 1'b0;
          llvl <= 1'b0;
        end
        else
        begin
          lrise <= 1'b0;
          if (!lvl)
          begin
            long_cnt <= '0;
            llvl <= 1'b0;
          end
          else if (!llvl && long_cnt == LW'(LONG_CYC - 1))
          begin
            lrise <= 1'b1;
            llvl <= 1'b1;
          end
          else if (!llvl)
            long_cnt <= long_cnt + 1'b1;
        end
      end
      assign src.lvl[i] = lvl;
      assign src.rise[i] = rise;
      assign src.long_rise[i] = lrise;
      assign src.long_lvl[i] = llvl;
    end
  endgenerate
endmodule // muif_debounce

// *** verilog/muif_defs.svh ***
// Constants for the meter user input function dispatcher
`ifndef MUIF_DEFS_SVH
`define MUIF_DEFS_SVH
// Source counts and field width
`define MUIF_N_IN 3
`define MUIF_N_KEY 5
`define MUIF_N_SRC 9
`define MUIF_DSP_CH 8
`define MUIF_FW 4
`define MUIF_NFUNC 16
// Clock rate and times in milliseconds
`define MUIF_CLK_KHZ 25000
`define MUIF_DEB_MS 10
`define MUIF_LONG_MS 3000
`define MUIF_FLASH_MS 1000
`define MUIF_VIEW_MS 1000
// Register byte addresses
`define MUIF_A_IN_FUNC 5'h00
`define MUIF_A_KEY_PRI 5'h04
`define MUIF_A_KEY_SEC 5'h08
`define MUIF_A_OFFSET 5'h0c
`define MUIF_A_STATUS 5'h10
`define MUIF_A_TOTAL 5'h14
`define MUIF_A_PEAK 5'h18
// Status bit positions
`define MUIF_ST_PROG_OK 0
`define MUIF_ST_ABS 1
`define MUIF_ST_HOLD 2
`define MUIF_ST_HOLD_ALL 3
`define MUIF_ST_SYNC 4
`define MUIF_ST_FLASH 5
`define MUIF_ST_TOT_RUN 6
`define MUIF_ST_MAX_RUN 7
`define MUIF_ST_VIEW 8
`define MUIF_ST_SRC 16
`endif

// *** verilog/muif_pkg.sv ***
// Types for the meter user input function dispatcher
package muif_pkg;
`include "muif_defs.svh"
  // Function assigned to one input or key
  typedef enum logic [`MUIF_FW-1:0] {
    MUIF_F_NONE, MUIF_F_PLOC, MUIF_F_ZERO, MUIF_F_RELABS, MUIF_F_HOLD, MUIF_F_HOLD_ALL,
    MUIF_F_SYNC, MUIF_F_BATCH, MUIF_F_TOT_SEL, MUIF_F_TOT_RST, MUIF_F_TOT_RSTEN,
    MUIF_F_TOT_EN, MUIF_F_MAX_SEL, MUIF_F_MAX_RST, MUIF_F_MAX_RSE
  } muif_func_t;
  // Display being shown
  typedef enum logic [1:0] {MUIF_V_INPUT, MUIF_V_TOTAL, MUIF_V_PEAK} muif_view_t;
endpackage

// *** verilog/muif_src_if.sv ***
// Cleaned source levels and events between debouncer and dispatcher
`timescale 1ns/1ps
interface muif_src_if #(parameter int N = 9);
  logic [N-1:0] lvl;
  logic [N-1:0] rise;
  logic [N-1:0] long_rise;
  logic [N-1:0] long_lvl;
  modport drv (output lvl, output rise, output long_rise, output long_lvl);
  modport use_side (input lvl, input rise, input long_rise, input long_lvl);
endinterface

// *** verilog/muif_top.sv ***
// Meter user input and function key dispatcher with Avalon-MM registers
// How it works
// - Three inputs and five keys, each given its own function code.
// - An input acts on its activation edge in display or program mode.
// - In display mode a key press runs primary, three-second hold runs secondary.
// - A key may carry a secondary function with an empty primary.
// - Shared level functions stay active while any assigned source is asserted.
// - Shared edge functions act on every activation edge of any source.
// - After reset every source carries the no-operation function.
// - Program lock-out blocks full programming unless the security code grants it.
// - Zero edge flashes indicator, subtracts shown value from stored offset.
// - Relative view includes offset by default; internals always use relative.
// - Input selects absolute while held; key toggles absolute on each press.
// - Each view change briefly lights the indicator naming the new view.
// - Display hold freezes shown value; everything else keeps running.
// - Hold-all stops processing, freezes display and outputs; serial keeps going.
// - Synchronise suspends everything; release restarts conversion in step.
// - Batch mode adds shown value once per edge instead of normal accumulation.
// - Totalizer view while held; display key overrides; totalizer keeps working.
// - Totalizer reset edge flashes, clears total, then continues as configured.
// - Reset-and-enable clears on edge, accumulates while held, holds on release.
// - Totalizer enable accumulates only while held and holds on release.
// - Peak view while held; display key overrides; peak tracking continues.
// - Peak reset edge flashes and loads peak with present value.
// - Reset-select-enable loads peak, tracks while held; display key overrides view.
`timescale 1ns/1ps
module muif_top
  import muif_pkg::*;
#(
  parameter int DW = 18,
  parameter int TW = 32,
  parameter int DEB_CYC = `MUIF_DEB_MS * `MUIF_CLK_KHZ,
  parameter int LONG_CYC = `MUIF_LONG_MS * `MUIF_CLK_KHZ,
  parameter int FLASH_CYC = `MUIF_FLASH_MS * `MUIF_CLK_KHZ,
  parameter int VIEW_CYC = `MUIF_VIEW_MS * `MUIF_CLK_KHZ
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Operator sources, active high
  input wire logic [`MUIF_N_IN-1:0] external_control_input,
  input wire logic [`MUIF_N_KEY-1:0] function_key,
  input wire logic display_cycle_key,
  // Meter state
  input wire logic program_mode,
  input wire logic code_granted,
  input wire logic signed [DW-1:0] gross_value,
  input wire logic sample_valid,
  // Meter controls
  output logic signed [TW-1:0] display_value,
  output muif_pkg::muif_view_t display_view,
  output logic reset_indicator,
  output logic gross_view_indicator,
  output logic net_view_indicator,
  output logic full_prog_allowed,
  output logic input_freeze,
  output logic outputs_freeze,
  output logic adc_suspend,
  output logic adc_restart
);
  localparam int FCW = $clog2(FLASH_CYC + 1);
  localparam int VCW = $clog2(VIEW_CYC + 1);
  localparam int NI = `MUIF_N_IN;
  localparam int NK = `MUIF_N_KEY;

  muif_src_if #(.N(`MUIF_N_SRC)) src ();

  logic [NI*`MUIF_FW-1:0] in_func;
  logic [NK*`MUIF_FW-1:0] key_pri;
  logic [NK*`MUIF_FW-1:0] key_sec;
  logic signed [DW-1:0] display_offset_value;
  logic signed [DW-1:0] rel_value;
  logic signed [TW-1:0] total;
  logic signed [DW-1:0] peak;
  logic [`MUIF_NFUNC-1:0] f_lvl;
  logic [`MUIF_NFUNC-1:0] f_edge;
  logic relabs_tgl;
  logic cfg_tot_gate;
  logic cfg_max_gate;
  logic cfg_batch;
  logic key_abs;
  logic view_abs;
  logic view_abs_d;
  logic sync_d;
  logic run;
  logic take;
  logic dsp_override;
  logic tot_run;
  logic max_run;
  logic [FCW-1:0] flash_cnt;
  logic [VCW-1:0] view_cnt;
  logic ack;
  logic [31:0] next_readdata;
  logic [31:0] status;

  // Clean all raw sources
  muif_debounce #(.N(`MUIF_N_SRC), .DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_deb (
    .ref_clk(ref_clk),
    .srst(srst),
    .raw({display_cycle_key, function_key, external_control_input}),
    .src(src.drv)
  );

  // Merge inputs and function keys into per-function levels and edges
  always_comb
  begin
    muif_func_t fn;
    fn = MUIF_F_NONE;
    f_lvl = '0;
    f_edge = '0;
    relabs_tgl = 1'b0;
    cfg_tot_gate = 1'b0;
    cfg_max_gate = 1'b0;
    cfg_batch = 1'b0;
    for (int i = 0; i < NI; i++)
    begin
      fn = muif_func_t'(in_func[i*`MUIF_FW +: `MUIF_FW]);
      f_lvl[fn] = f_lvl[fn] | src.lvl[i];
      if (fn != MUIF_F_RELABS)
        f_edge[fn] = f_edge[fn] | src.rise[i];
      cfg_tot_gate = cfg_tot_gate | (fn == MUIF_F_TOT_EN) | (fn == MUIF_F_TOT_RSTEN);
      cfg_max_gate = cfg_max_gate | (fn == MUIF_F_MAX_RSE);
      cfg_batch = cfg_batch | (fn == MUIF_F_BATCH);
    end
    for (int k = 0; k < 2 * NK; k++)
    begin
      // Primary slots first, then secondary slots
      if (k < NK)
        fn = muif_func_t'(key_pri[k*`MUIF_FW +: `MUIF_FW]);
      else
        fn = muif_func_t'(key_sec[(k-NK)*`MUIF_FW +: `MUIF_FW]);
      cfg_tot_gate = cfg_tot_gate | (fn == MUIF_F_TOT_EN) | (fn == MUIF_F_TOT_RSTEN);
      cfg_max_gate = cfg_max_gate | (fn == MUIF_F_MAX_RSE);
      cfg_batch = cfg_batch | (fn == MUIF_F_BATCH);
      if (!program_mode)
      begin
        if (k < NK)
        begin
          if (fn == MUIF_F_RELABS)
            relabs_tgl = relabs_tgl | src.rise[NI+k];
          else
          begin
            f_lvl[fn] = f_lvl[fn] | src.lvl[NI+k];
            f_edge[fn] = f_edge[fn] | src.rise[NI+k];
          end
        end
        else if (fn == MUIF_F_RELABS)
          relabs_tgl = relabs_tgl | src.long_rise[NI+k-NK];
        else
        begin
          f_lvl[fn] = f_lvl[fn] | src.long_lvl[NI+k-NK];
          f_edge[fn] = f_edge[fn] | src.long_rise[NI+k-NK];
        end
      end
    end
    f_lvl[MUIF_F_NONE] = 1'b0;
    f_edge[MUIF_F_NONE] = 1'b0;
  end

  // Processing runs unless held-all or synchronising
  assign run = !f_lvl[MUIF_F_HOLD_ALL] && !f_lvl[MUIF_F_SYNC];
  assign take = sample_valid && run;
  assign rel_value = gross_value + display_offset_value;
  assign input_freeze = f_lvl[MUIF_F_HOLD_ALL] || f_lvl[MUIF_F_SYNC];
  assign outputs_freeze = f_lvl[MUIF_F_HOLD_ALL] || f_lvl[MUIF_F_SYNC];
  assign adc_suspend = f_lvl[MUIF_F_SYNC];
  assign full_prog_allowed = !f_lvl[MUIF_F_PLOC] || code_granted;
  assign tot_run = !cfg_batch && (!cfg_tot_gate || f_lvl[MUIF_F_TOT_EN] || f_lvl[MUIF_F_TOT_RSTEN]);
  assign max_run = !cfg_max_gate || f_lvl[MUIF_F_MAX_RSE];

  // Absolute view toggled by key, held by input
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      key_abs <= 1'b0;
    else if (relabs_tgl && run)
      key_abs <= !key_abs;
  end
  assign view_abs = key_abs || f_lvl[MUIF_F_RELABS];

  // View-name indicator after each change
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      view_abs_d <= 1'b0;
      view_cnt <= '0;
    end
    else
    begin
      view_abs_d <= view_abs;
      if (view_abs != view_abs_d)
        view_cnt <= VCW'(VIEW_CYC);
      else if (view_cnt != '0)
        view_cnt <= view_cnt - 1'b1;
    end
  end
  assign gross_view_indicator = (view_cnt != '0) && view_abs_d;
  assign net_view_indicator = (view_cnt != '0) && !view_abs_d;

  // Reset indicator flash on zero, totalizer reset, reset-and-enable and peak reset edges
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      flash_cnt <= '0;
    else if (run && (f_edge[MUIF_F_ZERO] || f_edge[MUIF_F_TOT_RST] || f_edge[MUIF_F_TOT_RSTEN]
             || f_edge[MUIF_F_MAX_RST]))
      flash_cnt <= FCW'(FLASH_CYC);
    else if (flash_cnt != '0)
      flash_cnt <= flash_cnt - 1'b1;
  end
  assign reset_indicator = flash_cnt != '0;

  // Display offset: tare edge has priority over a software write
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      display_offset_value <= '0;
    else if (f_edge[MUIF_F_ZERO] && run)
      display_offset_value <= display_offset_value - rel_value;
    else if (avs_write && ack && avs_address == `MUIF_A_OFFSET)
      display_offset_value <= DW'(be_merge(32'(display_offset_value), avs_writedata, avs_byteenable));
  end

  // Totalizer accumulation, batch and clears
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      total <= '0;
    else if (run && (f_edge[MUIF_F_TOT_RST] || f_edge[MUIF_F_TOT_RSTEN]))
      total <= '0;
    else if (run && cfg_batch && f_edge[MUIF_F_BATCH])
      total <= total + TW'(rel_value);
    else if (take && tot_run)
      total <= total + TW'(rel_value);
  end

  // Peak tracking
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      peak <= '0;
    else if (run && (f_edge[MUIF_F_MAX_RST] || f_edge[MUIF_F_MAX_RSE]))
      peak <= rel_value;
    else if (take && max_run && rel_value > peak)
      peak <= rel_value;
  end

  // Display key cancels a maintained view until the next selection edge
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      dsp_override <= 1'b0;
    else if (src.rise[`MUIF_DSP_CH])
      dsp_override <= 1'b1;
    else if (f_edge[MUIF_F_TOT_SEL] || f_edge[MUIF_F_MAX_SEL] || f_edge[MUIF_F_MAX_RSE])
      dsp_override <= 1'b0;
  end

  // Selected view and shown value
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      display_view <= MUIF_V_INPUT;
      display_value <= '0;
    end
    else if (run && !f_lvl[MUIF_F_HOLD])
    begin
      if (!dsp_override && (f_lvl[MUIF_F_MAX_SEL] || f_lvl[MUIF_F_MAX_RSE]))
      begin
        display_view <= MUIF_V_PEAK;
        display_value <= TW'(peak);
      end
      else if (!dsp_override && f_lvl[MUIF_F_TOT_SEL])
      begin
        display_view <= MUIF_V_TOTAL;
        display_value <= total;
      end
      else
      begin
        display_view <= MUIF_V_INPUT;
        display_value <= view_abs ? TW'(gross_value) : TW'(rel_value);
      end
    end
  end

  // Restart pulse on synchronise release
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sync_d <= 1'b0;
      adc_restart <= 1'b0;
    end
    else
    begin
      sync_d <= f_lvl[MUIF_F_SYNC];
      adc_restart <= sync_d && !f_lvl[MUIF_F_SYNC];
    end
  end

  // Byte-lane merge for register writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    return r;
  endfunction

  // One wait cycle, then the access completes
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      ack <= 1'b0;
    else
      ack <= (avs_read || avs_write) && !ack;
  end

  // Function code registers, all no-operation after reset
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      in_func <= {NI{MUIF_F_NONE}};
      key_pri <= {NK{MUIF_F_NONE}};
      key_sec <= {NK{MUIF_F_NONE}};
    end
    else if (avs_write && ack)
    begin
      unique case (avs_address)
        `MUIF_A_IN_FUNC: in_func <= (NI*`MUIF_FW)'(be_merge(32'(in_func), avs_writedata, avs_byteenable));
        `MUIF_A_KEY_PRI: key_pri <= (NK*`MUIF_FW)'(be_merge(32'(key_pri), avs_writedata, avs_byteenable));
        `MUIF_A_KEY_SEC: key_sec <= (NK*`MUIF_FW)'(be_merge(32'(key_sec), avs_writedata, avs_byteenable));
        default: ;
      endcase
    end
  end

  // Status word
  always_comb
  begin
    status = '0;
    status[`MUIF_ST_PROG_OK] = full_prog_allowed;
    status[`MUIF_ST_ABS] = view_abs;
    status[`MUIF_ST_HOLD] = f_lvl[MUIF_F_HOLD];
    status[`MUIF_ST_HOLD_ALL] = f_lvl[MUIF_F_HOLD_ALL];
    status[`MUIF_ST_SYNC] = f_lvl[MUIF_F_SYNC];
    status[`MUIF_ST_FLASH] = reset_indicator;
    status[`MUIF_ST_TOT_RUN] = tot_run;
    status[`MUIF_ST_MAX_RUN] = max_run;
    status[`MUIF_ST_VIEW +: 2] = display_view;
    status[`MUIF_ST_SRC +: `MUIF_N_SRC] = src.lvl;
  end

  // Read multiplexer, captured in the wait cycle
  always_comb
  begin
    unique case (avs_address)
      `MUIF_A_IN_FUNC: next_readdata = 32'(in_func);
      `MUIF_A_KEY_PRI: next_readdata = 32'(key_pri);
      `MUIF_A_KEY_SEC: next_readdata = 32'(key_sec);
      `MUIF_A_OFFSET: next_readdata = 32'(display_offset_value);
      `MUIF_A_STATUS: next_readdata = status;
      `MUIF_A_TOTAL: next_readdata = 32'(total);
      `MUIF_A_PEAK: next_readdata = 32'(peak);
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack)
      avs_readdata <= next_readdata;
  end
endmodule // muif_top
